//--- rtl/timer_chan_defs.vh
/*
  Constants for the interval / event timer channel: reset values, mode
  codes and select codes.
  Assumes inclusion by bare name from the channel module only.
*/
`ifndef TIMER_CHAN_DEFS_VH
`define TIMER_CHAN_DEFS_VH

`define CNT_W           16
`define CNT_ZERO        16'h0000
`define RELOAD_RST      16'hffff
`define MODE_INTERVAL   1'b0
`define MODE_EVENT      1'b1
`define CKSRC_A         1'b0
`define CKSRC_B         1'b1
`define OUT_MODE_TOGGLE 1'b0
`define TIN_PIN         2'h0
`define TIN_SUB_DIV4    2'h1
`define TIN_SUB_DIV2    2'h2
`define TIN_RTC         2'h3

`endif

//--- rtl/interval_event_timer_channel.v
/*
  One timer channel: interval timer / square wave output and external
  event counter.
  Assumes prescaled clock A/B and sub-clock ticks arrive as one-cycle
  enables from mclk logic; the event pin and the rtc event come from
  outside and are synchronised here. Software writes arrive as
  one-cycle write strobes with their data.
*/
`timescale 1ns/1ps
`include "timer_chan_defs.vh"

// Function
// - Output level bit written 0 gives low, 1 gives high; idle level.
// - Output enable 1 lets counting drive output; 0 freezes it.
// - Output mode 0 selects toggle on each channel interrupt.
// - Clock gate 0 stops the unit and ignores all register writes.
// - Clock gate 1 allows writes; channel starts out stopped.
// - Timer input selects pin, sub-clock /4, /2 or rtc event.
// - Stopped channel holds output where it stands; a level write sets it.
// - Start trigger sets running flag; trigger self-clears.
// - Interval first tick loads reload; irq/toggle if start select.
// - Interval: decrement per tick; at zero reload, irq, toggle.
// - Halt trigger clears running; counter and output freeze.
// - Clock gate 0 initialises all registers, level bit to 0.
// - Event mode start loads reload immediately.
// - Event mode: decrement per edge; at zero reload and irq.
// - Event mode reload rewrite takes effect next period.
// - Clock source bit selects prescaled clock A or B.
// - Interval reload rewrite takes effect next period.
module interval_event_timer_channel #(
  parameter CNT_W = `CNT_W
) (
  input  wire             mclk,
  input  wire             resetn,
  input  wire             unit_clock_gate,
  input  wire             prescaled_clk_a,
  input  wire             prescaled_clk_b,
  input  wire             subclk_tick,
  input  wire             rtc_interval_event,
  input  wire             event_input_pin,
  input  wire             wr_mode,
  input  wire             mode_sel_in,
  input  wire             clock_source_in,
  input  wire             use_timer_input_in,
  input  wire             start_irq_select_in,
  input  wire             edge_rise_in,
  input  wire             edge_fall_in,
  input  wire             wr_input_sel,
  input  wire             input_source_select_in,
  input  wire             subclock_divide_select_in,
  input  wire             rtc_input_select_in,
  input  wire             wr_reload,
  input  wire [CNT_W-1:0] reload_in,
  input  wire             wr_out,
  input  wire             out_level_in,
  input  wire             out_enable_in,
  input  wire             out_invert_in,
  input  wire             out_mode_in,
  input  wire             start_trigger,
  input  wire             halt_trigger,
  output reg  [CNT_W-1:0] down_counter,
  output reg              running_flag,
  output reg              channel_irq,
  output reg              timer_output_pin,
  output reg              pin_is_timer
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg             mode_q;
  reg             cksrc_q;
  reg             use_tin_q;
  reg             start_irq_q;
  reg             edge_rise_q;
  reg             edge_fall_q;
  reg             tis_q;
  reg             subclock_divide_select_q;
  reg             rtcis_q;
  reg [CNT_W-1:0] reload_q;
  reg             sub_div4_q;
  reg             out_enable_q;
  reg             out_invert_q;
  reg             out_mode_q;
  reg             first_q;
  reg             sub_div_q;
  reg [1:0]       pin_sync_q;
  reg [1:0]       rtc_sync_q;
  reg             pin_prev_q;
  reg             rtc_prev_q;

  wire gate_off = ~resetn | ~unit_clock_gate;
  // Writes only land while the unit is clocked
  wire wr_ok    = unit_clock_gate;

  function [1:0] tin_code;
    input tis;
    input subclock_divide_select;
    input rtcis;
    begin
      if (rtcis)
        tin_code = `TIN_RTC;
      else if (!tis)
        tin_code = `TIN_PIN;
      else if (subclock_divide_select)
        tin_code = `TIN_SUB_DIV2;
      else
        tin_code = `TIN_SUB_DIV4;
    end
  endfunction

  always @(posedge mclk) begin
    if (gate_off) begin
      mode_q       <= `MODE_INTERVAL;
      cksrc_q      <= `CKSRC_A;
      use_tin_q    <= 1'b0;
      start_irq_q  <= 1'b0;
      edge_rise_q  <= 1'b1;
      edge_fall_q  <= 1'b0;
      tis_q        <= 1'b0;
      subclock_divide_select_q       <= 1'b0;
      rtcis_q      <= 1'b0;
      reload_q     <= `RELOAD_RST;
      out_enable_q <= 1'b0;
      out_invert_q <= 1'b0;
      out_mode_q   <= `OUT_MODE_TOGGLE;
    end else if (wr_ok) begin
      // Mode bits are frozen by software convention while running
      if (wr_mode) begin
        mode_q      <= mode_sel_in;
        cksrc_q     <= clock_source_in;
        use_tin_q   <= use_timer_input_in;
        start_irq_q <= start_irq_select_in;
        edge_rise_q <= edge_rise_in;
        edge_fall_q <= edge_fall_in;
      end
      if (wr_input_sel) begin
        tis_q   <= input_source_select_in;
        subclock_divide_select_q  <= subclock_divide_select_in;
        rtcis_q <= rtc_input_select_in;
      end
      // New reload is only sampled at the next load point
      if (wr_reload)
        reload_q <= reload_in;
      if (wr_out) begin
        out_enable_q <= out_enable_in;
        out_invert_q <= out_invert_in;
        out_mode_q   <= out_mode_in;
      end
    end
  end

  // ****************************************************************
  // Count clock selection and input synchronisers
  // ****************************************************************
  wire op_clk = (cksrc_q == `CKSRC_B) ? prescaled_clk_b
                                      : prescaled_clk_a;

  always @(posedge mclk) begin
    if (gate_off) begin
      pin_sync_q <= 2'h0;
      rtc_sync_q <= 2'h0;
      pin_prev_q <= 1'b0;
      rtc_prev_q <= 1'b0;
      sub_div_q  <= 1'b0;
      sub_div4_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], event_input_pin};
      rtc_sync_q <= {rtc_sync_q[0], rtc_interval_event};
      // Edge history advances on operation clock ticks only
      if (op_clk) begin
        pin_prev_q <= pin_sync_q[1];
        rtc_prev_q <= rtc_sync_q[1];
      end
      if (subclk_tick)
        sub_div_q <= ~sub_div_q;
      // Second divider stage gives a true quarter of the sub-clock
      if (subclk_tick & sub_div_q)
        sub_div4_q <= ~sub_div4_q;
    end
  end
  wire pin_edge = op_clk &
                  ((edge_rise_q & pin_sync_q[1] & ~pin_prev_q) |
                   (edge_fall_q & ~pin_sync_q[1] & pin_prev_q));
  wire rtc_edge = op_clk & rtc_sync_q[1] & ~rtc_prev_q;
  reg  tin_tick;
  always @* begin
    case (tin_code(tis_q, subclock_divide_select_q, rtcis_q))
      `TIN_PIN:      tin_tick = pin_edge;
      `TIN_SUB_DIV2: tin_tick = subclk_tick & sub_div_q;
      `TIN_SUB_DIV4: tin_tick = subclk_tick & sub_div_q & sub_div4_q;
      `TIN_RTC:      tin_tick = rtc_edge;
      default:       tin_tick = 1'b0;
    endcase
  end
  wire interval_tick = use_tin_q ? tin_tick : op_clk;
  wire event_tick    = pin_edge;

  // ****************************************************************
  // Counter, running flag, interrupt and output
  // ****************************************************************
  wire start_ok = wr_ok & start_trigger;
  wire halt_ok  = wr_ok & halt_trigger;
  wire tick     = (mode_q == `MODE_EVENT) ? event_tick : interval_tick;
  wire at_zero  = (down_counter == `CNT_ZERO);
  reg  irq_d;

  always @* begin
    irq_d = 1'b0;
    if (running_flag & tick & ~halt_ok) begin
      if (mode_q == `MODE_INTERVAL && first_q)
        irq_d = start_irq_q;
      else if (at_zero && !first_q)
        irq_d = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (gate_off) begin
      down_counter     <= `CNT_ZERO;
      running_flag     <= 1'b0;
      first_q          <= 1'b0;
      channel_irq      <= 1'b0;
      timer_output_pin <= 1'b0;
      pin_is_timer     <= 1'b0;
    end else begin
      channel_irq  <= irq_d;
      pin_is_timer <= 1'b1;
      if (halt_ok) begin
        running_flag <= 1'b0;
      end else if (start_ok) begin
        running_flag <= 1'b1;
        if (mode_q == `MODE_EVENT) begin
          down_counter <= reload_q;
          first_q      <= 1'b0;
        end else if (!running_flag) begin
          first_q <= 1'b1;
        end
      end else if (running_flag & tick) begin
        if (first_q || at_zero)
          down_counter <= reload_q;
        else
          down_counter <= down_counter - 1'b1;
        first_q <= 1'b0;
      end
      // A level write sets the pin; a halt leaves it where it stands
      if (wr_ok & wr_out)
        timer_output_pin <= out_level_in;
      else if (out_enable_q && irq_d && out_mode_q == `OUT_MODE_TOGGLE)
        timer_output_pin <= ~timer_output_pin;
    end
  end

endmodule // interval_event_timer_channel

//--- dv/timer_chan_monitor.sv
/* Port checker for the timer channel.
   Assumes a bind from the bench top and one mclk domain. */
`timescale 1ns/1ps
module timer_chan_monitor #(
  parameter CNT_W = 16
) (
  input wire             mclk,
  input wire             resetn,
  input wire             unit_clock_gate,
  input wire             start_trigger,
  input wire             halt_trigger,
  input wire             wr_mode,
  input wire             mode_sel_in,
  input wire             wr_reload,
  input wire [CNT_W-1:0] reload_in,
  input wire             wr_out,
  input wire             out_level_in,
  input wire [CNT_W-1:0] down_counter,
  input wire             running_flag,
  input wire             channel_irq,
  input wire             timer_output_pin,
  input wire             pin_is_timer
);
  // Shadow of the writable state the ports cannot show
  reg [CNT_W-1:0] rl_q;
  reg             ev_q;
  reg             lvl_q;
  wire            wok = resetn && unit_clock_gate;
  always @(posedge mclk) begin
    if (!wok) begin
      rl_q  <= {CNT_W{1'b1}};
      ev_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      if (wr_reload) rl_q <= reload_in;
      if (wr_mode) ev_q <= mode_sel_in;
      if (wr_out) lvl_q <= out_level_in;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  gate_off_a: assert property (
    !unit_clock_gate |=> !running_flag && !pin_is_timer && down_counter == 0)
    else $error("gate off did not clear state");
  start_run_a: assert property (
    start_trigger && !halt_trigger && unit_clock_gate |=> running_flag)
    else $error("start did not set running");
  halt_stop_a: assert property (
    halt_trigger && unit_clock_gate |=> !running_flag)
    else $error("halt did not stop");
  cnt_frozen_a: assert property (
    !running_flag && !start_trigger && unit_clock_gate |=> $stable(down_counter))
    else $error("counter moved while stopped");
  out_level_a: assert property (
    wr_out && wok && !running_flag && !start_trigger
      |-> ##[1:2] timer_output_pin == lvl_q)
    else $error("stopped output not at level");
  irq_run_a: assert property (
    channel_irq |-> $past(running_flag))
    else $error("interrupt while stopped");
  ev_load_a: assert property (
    start_trigger && !halt_trigger && !running_flag && ev_q && !wr_reload
      && unit_clock_gate |=> down_counter == rl_q)
    else $error("event start did not load");
  irq_rel_a: assert property (
    channel_irq |-> down_counter == rl_q)
    else $error("no reload with interrupt");
  cover property (channel_irq && ev_q);
  cover property (halt_trigger && running_flag);
  cover property (wr_out && !running_flag);
endmodule // timer_chan_monitor

//--- dv/event_source.sv
/* Far-side model: drives the event pin with n pulses on request.
   Assumes go is a one-cycle request sampled at mclk rise. */
`timescale 1ns/1ps
module event_source (
  input  wire       mclk,
  input  wire       go,
  input  wire [3:0] n,
  output reg        pin,
  output reg        busy
);
  integer k;
  // Three cycles per level so the two-flop sync sees every edge
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (go) begin
        busy <= 1'b1;
        for (k = 0; k < 2 * n; k = k + 1) begin
          pin <= ~pin;
          repeat (3) @(posedge mclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // event_source

//--- dv/interval_event_timer_channel_tb_top.sv
/* Bench top: strobe tasks, event source, monitor bind.
   Assumes a 40 MHz mclk and the strobe contract of the channel. */
`timescale 1ns/1ps
module interval_event_timer_channel_tb_top;
  reg        mclk = 1'b0;
  reg        resetn, gate, ck_b, sub, rtc, go;
  reg        wr_mode, mode_sel, ck_src, use_ti, st_irq, e_rise;
  reg        wr_isel, tis, subclock_divide_select, rtcis, wr_rel, wr_out, lvl, oen;
  reg        start, halt;
  reg [15:0] rel, sv;
  reg [3:0]  dv, n_ev;
  wire[15:0] cnt;
  wire       run, irq, tout, pmode, ev_pin, busy;
  integer    n_mismatch = 0, tests_run = 0, nirq = 0, a, c, k;
  event_source src (.mclk(mclk), .go(go), .n(n_ev), .pin(ev_pin),
    .busy(busy));
  interval_event_timer_channel dut (.mclk(mclk), .resetn(resetn),
    .unit_clock_gate(gate), .prescaled_clk_a(1'b1), .prescaled_clk_b(ck_b),
    .subclk_tick(sub), .rtc_interval_event(rtc), .event_input_pin(ev_pin),
    .wr_mode(wr_mode), .mode_sel_in(mode_sel), .clock_source_in(ck_src),
    .use_timer_input_in(use_ti), .start_irq_select_in(st_irq),
    .edge_rise_in(e_rise), .edge_fall_in(1'b0), .wr_input_sel(wr_isel),
    .input_source_select_in(tis), .subclock_divide_select_in(subclock_divide_select),
    .rtc_input_select_in(rtcis), .wr_reload(wr_rel), .reload_in(rel),
    .wr_out(wr_out), .out_level_in(lvl), .out_enable_in(oen),
    .out_invert_in(1'b0),
    .out_mode_in(1'b0), .start_trigger(start),
    .halt_trigger(halt), .down_counter(cnt), .running_flag(run),
    .channel_irq(irq), .timer_output_pin(tout), .pin_is_timer(pmode));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    dv <= dv + 4'h1;
    ck_b <= dv[0];
    sub <= dv[1:0] == 2'h3;
    rtc <= dv[3];
  end
  always @(posedge mclk) if (irq === 1'b1) nirq <= nirq + 1;
  task step(input integer n); repeat (n) @(negedge mclk); endtask
  task chk(input [15:0] got, input [15:0] exp); begin
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  // Strobe k: 0 mode, 1 input select, 2 reload, 3 output, 4 start, 5 halt
  task wr(input [2:0] k); begin
    {halt, start, wr_out, wr_rel, wr_isel, wr_mode} = 6'h1 << k;
    step(1);
    {halt, start, wr_out, wr_rel, wr_isel, wr_mode} = 6'h0;
    step(1);
  end endtask
  task wait_irq; begin
    c = 0;
    while (irq !== 1'b1 && c < 200) begin step(1); c = c + 1; end
    if (c == 200) begin chk(1'b0, 1'b1); complete_run; end
  end endtask
  task gap(input [15:0] e); begin
    wait_irq; step(1); wait_irq; chk(c + 1, e);
  end endtask
  task pulses(input [3:0] k); begin
    n_ev = k; go = 1'b1; step(1); go = 1'b0; c = 0;
    while (busy && c < 200) begin step(1); c = c + 1; end
    if (c == 200) begin chk(1'b0, 1'b1); complete_run; end
    step(4);
  end endtask
  task complete_run; begin
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  initial begin
    {resetn, gate, go, dv, ck_b, sub, rtc, n_ev} = 0;
    {wr_mode, mode_sel, ck_src, use_ti, st_irq, e_rise, wr_isel} = 0;
    {tis, subclock_divide_select, rtcis, wr_rel, wr_out, lvl, oen, start, halt, rel} = 0;
    gate = 1'b1; step(3); resetn = 1'b1; step(2);
    chk(pmode, 1); chk(run, 0); chk(tout, 0);
    gate = 1'b0; rel = 16'h7; wr(2); gate = 1'b1; step(1);
    {mode_sel, use_ti, e_rise} = 3'h7; wr(0); wr(4);
    chk(cnt, 16'hffff);
    wr(5); rel = 16'h3; wr(2); wr(4); chk(cnt, 16'h3);
    a = nirq; pulses(4); chk(cnt, 16'h3); chk(nirq - a, 1);
    rel = 16'h1; wr(2); pulses(6); chk(cnt, 16'h1);
    chk(nirq - a, 3); $display("event test done");
    wr(5); mode_sel = 1'b0; st_irq = 1'b1; wr(0);
    for (k = 0; k < 3; k = k + 1) begin
      {rtcis, tis, subclock_divide_select} = k == 0 ? 3'h4 : (k == 1 ? 3'h2 : 3'h3);
      wr(1); wr(4); wait_irq; wr(5);
    end
    use_ti = 1'b0; oen = 1'b1; wr(0); wr(3); rel = 16'h2; wr(2); wr(4);
    wait_irq; chk(c, 0); chk(tout, 1); gap(3);
    wr(5); st_irq = 1'b0; wr(0); wr(4); wait_irq; chk(c, 3);
    rel = 16'h5; wr(2); gap(6);
    $display("interval test done");
    wr(5); sv = cnt; a = tout; step(5);
    chk(cnt, sv); chk(run, 0); chk(tout, a);
    oen = 1'b0; lvl = 1'b1; wr(3); chk(tout, 1);
    lvl = 1'b0; wr(3); chk(tout, 0);
    $display("halt test done");
    ck_src = 1'b1; wr(0); rel = 16'h2; wr(2);
    oen = 1'b1; wr(3); wr(4);
    gap(6);
    $display("clock b test done");
    complete_run;
  end
endmodule // interval_event_timer_channel_tb_top
bind interval_event_timer_channel timer_chan_monitor #(.CNT_W(CNT_W)) mon (
  .mclk(mclk), .resetn(resetn), .unit_clock_gate(unit_clock_gate),
  .start_trigger(start_trigger), .halt_trigger(halt_trigger),
  .wr_mode(wr_mode), .mode_sel_in(mode_sel_in), .wr_reload(wr_reload),
  .reload_in(reload_in), .wr_out(wr_out), .out_level_in(out_level_in),
  .down_counter(down_counter), .running_flag(running_flag),
  .channel_irq(channel_irq), .timer_output_pin(timer_output_pin),
  .pin_is_timer(pin_is_timer));
